// file: logic/agc_cfg.sv
`include "agc_cfg_defines.svh"
module agc_cfg (
    // Clock and reset
    input  wire logic       CLOCK,
    input  wire logic       SRST,
    // Serial configuration port
    input  wire logic       CSN,
    input  wire logic       SCLK,
    input  wire logic       MOSI,
    output logic            MISO,
    output logic            MISO_OE,
    // Gain step requests
    input  wire logic       AMP_DOWN,
    input  wire logic       AMP_UP,
    input  wire logic       DIG_DOWN,
    input  wire logic       DIG_UP,
    // Measured levels in dB
    input  wire logic [7:0] CHAN_AMPL,
    input  wire logic [7:0] GAIN_RED_DB,
    input  wire logic [7:0] RSSI,
    input  wire logic [7:0] RSSI_REF,
    // Gain state and decisions
    output logic [2:0]      DIG_STEP,
    output logic [2:0]      AMP1_STEP,
    output logic [2:0]      AMP2_STEP,
    output logic [7:0]      TARGET_DB,
    output logic            CARRIER_SENSE
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] csn_s_q;
    logic [2:0] sclk_s_q;
    logic [1:0] mosi_s_q;
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            csn_s_q  <= 2'h3;
            sclk_s_q <= 3'h0;
            mosi_s_q <= 2'h0;
        end else begin
            csn_s_q  <= {csn_s_q[0], CSN};
            sclk_s_q <= {sclk_s_q[1:0], SCLK};
            mosi_s_q <= {mosi_s_q[0], MOSI};
        end
    end
    logic csn;
    logic sclk_rise;
    logic sclk_fall;
    assign csn       = csn_s_q[1];
    assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    // ----------------------------------------------------------------
    // Serial slave and registers
    // ----------------------------------------------------------------
    agc_cfg_pkg::agc_spi_st_t st_q;
    agc_cfg_pkg::agc_spi_st_t st_d;
    logic [7:0] sh_q, sh_d;
    logic [2:0] cnt_q, cnt_d;
    logic       rd_q, rd_d;
    logic [5:0] adr_q, adr_d;
    logic       miso_q, miso_d;
    logic [7:0] lim_q, lim_d;
    logic [7:0] pcs_q, pcs_d;
    logic [7:0] rdata;
    logic [7:0] hdr;
    assign hdr   = {sh_q[6:0], mosi_s_q[1]};
    assign rdata = (hdr[5:0] == `AGC_OFS_LIMITS)  ? lim_q :
                   (hdr[5:0] == `AGC_OFS_PRIO_CS) ? pcs_q : 8'h00;
    always_comb begin
        st_d   = st_q;
        sh_d   = sh_q;
        cnt_d  = cnt_q;
        rd_d   = rd_q;
        adr_d  = adr_q;
        miso_d = miso_q;
        lim_d  = lim_q;
        pcs_d  = pcs_q;
        if (csn) begin
            st_d   = agc_cfg_pkg::SPI_IDLE;
            miso_d = 1'b0;
        end else begin
            unique case (st_q)
                agc_cfg_pkg::SPI_IDLE: begin
                    st_d  = agc_cfg_pkg::SPI_HDR;
                    cnt_d = 3'h0;
                end
                agc_cfg_pkg::SPI_HDR: if (sclk_rise) begin
                    sh_d  = {sh_q[6:0], mosi_s_q[1]};
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'h7) begin
                        rd_d   = sh_d[`AGC_HDR_READ];
                        adr_d  = sh_d[5:0];
                        st_d   = agc_cfg_pkg::SPI_DATA;
                        sh_d   = sh_d[`AGC_HDR_READ] ? rdata : 8'h00;
                        miso_d = sh_d[7];
                    end
                end
                agc_cfg_pkg::SPI_DATA: begin
                    if (rd_q && sclk_fall && cnt_q != 3'h0) begin
                        sh_d   = {sh_q[6:0], 1'b0};
                        miso_d = sh_q[6];
                    end
                    if (sclk_rise) begin
                        cnt_d = cnt_q + 3'h1;
                        if (!rd_q)
                            sh_d = {sh_q[6:0], mosi_s_q[1]};
                        if (cnt_q == 3'h7) begin
                            st_d = agc_cfg_pkg::SPI_DONE;
                            if (!rd_q && adr_q == `AGC_OFS_LIMITS)
                                lim_d = sh_d;
                            if (!rd_q && adr_q == `AGC_OFS_PRIO_CS)
                                pcs_d = sh_d & `AGC_PRIO_CS_MASK;
                        end
                    end
                end
                agc_cfg_pkg::SPI_DONE: if (sclk_fall)
                    miso_d = 1'b0;
            endcase
        end
    end
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st_q   <= agc_cfg_pkg::SPI_IDLE;
            sh_q   <= 8'h00;
            cnt_q  <= 3'h0;
            rd_q   <= 1'b0;
            adr_q  <= 6'h00;
            miso_q <= 1'b0;
            lim_q  <= `AGC_RST_LIMITS;
            pcs_q  <= `AGC_RST_PRIO_CS;
        end else begin
            st_q   <= st_d;
            sh_q   <= sh_d;
            cnt_q  <= cnt_d;
            rd_q   <= rd_d;
            adr_q  <= adr_d;
            miso_q <= miso_d;
            lim_q  <= lim_d;
            pcs_q  <= pcs_d;
        end
    end
    assign MISO    = miso_q;
    assign MISO_OE = ~csn;
    // ----------------------------------------------------------------
    // Gain step control
    // ----------------------------------------------------------------
    // Caps shrink the allowed range; an amplifier step above a fresh cap is walked
    // down one step a cycle, while the digital step is cut to its cap in one cycle.
    logic [1:0] dg_cap;
    logic [2:0] amp_cap;
    logic       prio;
    logic [2:0] dig_lim;
    logic [3:0] amp_lim;
    logic [3:0] amp_sum;
    logic [2:0] dig_q, dig_d;
    logic [2:0] a1_q, a1_d;
    logic [2:0] a2_q, a2_d;
    logic       amp_dn;
    assign dg_cap  = lim_q[`AGC_DG_MSB:`AGC_DG_LSB];
    assign amp_cap = lim_q[`AGC_AMP_MSB:`AGC_AMP_LSB];
    assign prio    = pcs_q[`AGC_PRIO_BIT];
    assign dig_lim = `AGC_STEP_MAX - {1'b0, dg_cap};
    assign amp_lim = `AGC_AMP_SUM - {amp_cap, 1'b0};
    assign amp_sum = {1'b0, a1_q} + {1'b0, a2_q};
    always_comb begin
        dig_d  = dig_q;
        a1_d   = a1_q;
        a2_d   = a2_q;
        amp_dn = AMP_DOWN || (amp_sum > amp_lim);
        if (dig_q > dig_lim)
            dig_d = dig_lim;
        else if (DIG_DOWN && dig_q != 3'h0)
            dig_d = dig_q - 3'h1;
        else if (DIG_UP && dig_q < dig_lim)
            dig_d = dig_q + 3'h1;
        if (amp_dn) begin
            if (prio ? (a1_q != 3'h0) : (a2_q == 3'h0)) begin
                if (a1_q != 3'h0)
                    a1_d = a1_q - 3'h1;
            end else if (a2_q != 3'h0) begin
                a2_d = a2_q - 3'h1;
            end
        end else if (AMP_UP && amp_sum < amp_lim) begin
            if (prio ? (a2_q != `AGC_STEP_MAX)
                     : (a1_q == `AGC_STEP_MAX))
                a2_d = a2_q + 3'h1;
            else
                a1_d = a1_q + 3'h1;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            dig_q <= `AGC_STEP_MAX;
            a1_q  <= `AGC_STEP_MAX;
            a2_q  <= `AGC_STEP_MAX;
        end else begin
            dig_q <= dig_d;
            a1_q  <= a1_d;
            a2_q  <= a2_d;
        end
    end
    assign DIG_STEP  = dig_q;
    assign AMP1_STEP = a1_q;
    assign AMP2_STEP = a2_q;
    // ----------------------------------------------------------------
    // Carrier sense
    // ----------------------------------------------------------------
    // Signed 9-bit math keeps negative offsets and rises from wrapping.
    logic [7:0] tgt_db;
    logic [7:0] rel_db;
    logic [3:0] abs_f;
    logic [8:0] level;
    logic [8:0] thr;
    logic [8:0] rise;
    logic       cs_d, cs_q;
    logic [7:0] tgt_q;
    assign abs_f = pcs_q[`AGC_ABS_MSB:`AGC_ABS_LSB];
    always_comb begin
        unique case (lim_q[`AGC_TGT_MSB:`AGC_TGT_LSB])
            3'h0: tgt_db = `AGC_TGT0;
            3'h1: tgt_db = `AGC_TGT1;
            3'h2: tgt_db = `AGC_TGT2;
            3'h3: tgt_db = `AGC_TGT3;
            3'h4: tgt_db = `AGC_TGT4;
            3'h5: tgt_db = `AGC_TGT5;
            3'h6: tgt_db = `AGC_TGT6;
            3'h7: tgt_db = `AGC_TGT7;
        endcase
        unique case (pcs_q[`AGC_REL_MSB:`AGC_REL_LSB])
            2'h0: rel_db = 8'h00;
            2'h1: rel_db = `AGC_REL1;
            2'h2: rel_db = `AGC_REL2;
            2'h3: rel_db = `AGC_REL3;
        endcase
    end
    assign level = {1'b0, CHAN_AMPL} + {1'b0, GAIN_RED_DB};
    assign thr   = {1'b0, tgt_db} + {{5{abs_f[3]}}, abs_f};
    assign rise  = {1'b0, RSSI} - {1'b0, RSSI_REF};
    always_comb begin
        cs_d = 1'b0;
        if (abs_f != `AGC_ABS_OFF && level >= thr)
            cs_d = 1'b1;
        if (rel_db != 8'h00 && !rise[8] && rise[7:0] >= rel_db)
            cs_d = 1'b1;
    end
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            cs_q  <= 1'b0;
            tgt_q <= `AGC_TGT3;
        end else begin
            cs_q  <= cs_d;
            tgt_q <= tgt_db;
        end
    end
    assign CARRIER_SENSE = cs_q;
    assign TARGET_DB     = tgt_q;
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    dig_cap_a: assert property (
        $past(dig_q) <= $past(dig_lim) |-> dig_q <= $past(dig_lim))
        else $error("digital step above cap");
    amp_cap_a: assert property (
        $past(amp_sum) <= $past(amp_lim) |-> amp_sum <= $past(amp_lim))
        else $error("amplifier sum above cap");
    tgt_map_a: assert property (
        lim_q[2:0] == 3'h0 ##1 lim_q[2:0] == 3'h0 |-> TARGET_DB == 8'h18)
        else $error("target map wrong");
    prio_one_a: assert property (
        prio && AMP_DOWN && a1_q != 3'h0 && amp_sum <= amp_lim
        |=> a2_q == $past(a2_q) && a1_q == $past(a1_q) - 3'h1)
        else $error("stage one not lowered first");
    prio_zero_a: assert property (
        !prio && AMP_DOWN && a2_q != 3'h0
        |=> a1_q == $past(a1_q) && a2_q == $past(a2_q) - 3'h1)
        else $error("stage two not lowered first");
    rel_off_a: assert property (
        pcs_q[5:4] == 2'h0 && abs_f == `AGC_ABS_OFF |=> !CARRIER_SENSE)
        else $error("sense with both criteria off");
    abs_thr_a: assert property (
        abs_f != `AGC_ABS_OFF && level >= thr |=> CARRIER_SENSE)
        else $error("absolute threshold missed");
    abs_lvl_a: assert property (
        GAIN_RED_DB == 8'h00 && abs_f == 4'h0 && pcs_q[5:4] == 2'h0
        && CHAN_AMPL < tgt_db |=> !CARRIER_SENSE)
        else $error("level not the filter amplitude");
    walk_down_a: assert property (
        amp_sum > amp_lim && a1_q != 3'h0 && a2_q != 3'h0
        |=> amp_sum == $past(amp_sum) - 4'h1)
        else $error("over-cap gain not reduced");
    wr_cov_c:  cover property (st_q == agc_cfg_pkg::SPI_DATA && !rd_q
        && sclk_rise && cnt_q == 3'h7);
    rd_cov_c:  cover property (st_q == agc_cfg_pkg::SPI_DATA && rd_q
        && sclk_rise && cnt_q == 3'h7);
    cs_cov_c:  cover property (!CARRIER_SENSE ##1 CARRIER_SENSE);
    cap_cov_c: cover property (amp_sum > amp_lim ##1 amp_sum == amp_lim);
endmodule : agc_cfg

// file: logic/agc_cfg_defines.svh
`ifndef AGC_CFG_DEFINES_SVH
`define AGC_CFG_DEFINES_SVH
// Contract
// - Digital gain cap field 7:6 bars the top N digital steps; zero bars none.
// - Amplifier cap field 5:3 lowers combined two-stage gain limit; zero is full.
// - Target field 2:0 selects 24..42 dB amplitude target; resets to 011.
// - Priority bit 6, reset 1: set lowers stage one first, else stage two.
// - Relative field 5:4 asserts sense on 6/10/14 dB rise; 00 disables.
// - Absolute field 3:0 is signed 1 dB offset from the amplitude target.
// - Absolute field pattern 1000 disables the absolute criterion.
// - Absolute compare level equals filter amplitude while gain is unreduced.

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define AGC_OFS_LIMITS     6'h1b
`define AGC_OFS_PRIO_CS    6'h1c
`define AGC_RST_LIMITS     8'h03
`define AGC_RST_PRIO_CS    8'h40
`define AGC_PRIO_CS_MASK   8'h7f
`define AGC_ABS_OFF        4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AGC_DG_MSB   7
`define AGC_DG_LSB   6
`define AGC_AMP_MSB  5
`define AGC_AMP_LSB  3
`define AGC_TGT_MSB  2
`define AGC_TGT_LSB  0
`define AGC_PRIO_BIT 6
`define AGC_REL_MSB  5
`define AGC_REL_LSB  4
`define AGC_ABS_MSB  3
`define AGC_ABS_LSB  0

// ----------------------------------------------------------------
// Serial header and gain steps
// ----------------------------------------------------------------
`define AGC_HDR_READ 7
`define AGC_STEP_MAX 3'h7
`define AGC_AMP_SUM  4'he

// ----------------------------------------------------------------
// Levels in dB
// ----------------------------------------------------------------
`define AGC_TGT0 8'h18
`define AGC_TGT1 8'h1b
`define AGC_TGT2 8'h1e
`define AGC_TGT3 8'h21
`define AGC_TGT4 8'h24
`define AGC_TGT5 8'h26
`define AGC_TGT6 8'h28
`define AGC_TGT7 8'h2a
`define AGC_REL1 8'h06
`define AGC_REL2 8'h0a
`define AGC_REL3 8'h0e
`endif

// file: logic/agc_cfg_pkg.sv
package agc_cfg_pkg;
    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_HDR,
        SPI_DATA,
        SPI_DONE
    } agc_spi_st_t;
endpackage : agc_cfg_pkg

// file: tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic       csn = 1'b1;
    logic       sclk = 1'b0;
    logic       mosi = 1'b0;
    logic       amp_dn = 1'b0;
    logic       amp_up = 1'b0;
    logic       dig_dn = 1'b0;
    logic       dig_up = 1'b0;
    logic [7:0] chan_ampl = 8'h00;
    logic [7:0] gain_red = 8'h00;
    logic [7:0] rssi = 8'h00;
    logic [7:0] rssi_ref = 8'h00;
    logic       miso;
    logic       miso_oe;
    logic [2:0] dig_step;
    logic [2:0] amp1_step;
    logic [2:0] amp2_step;
    logic [7:0] target_db;
    logic       carrier_sense;
    int         err_count = 0;
    int         tests_run = 0;
    logic [7:0] tgt [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21,
                            8'h24, 8'h26, 8'h28, 8'h2a};
    logic [7:0] rel [4] = '{8'h00, 8'h06, 8'h0a, 8'h0e};

    always #2.5 clock = ~clock;

    agc_cfg u_agc_cfg (
        .CLOCK         (clock),
        .SRST          (srst),
        .CSN           (csn),
        .SCLK          (sclk),
        .MOSI          (mosi),
        .MISO          (miso),
        .MISO_OE       (miso_oe),
        .AMP_DOWN      (amp_dn),
        .AMP_UP        (amp_up),
        .DIG_DOWN      (dig_dn),
        .DIG_UP        (dig_up),
        .CHAN_AMPL     (chan_ampl),
        .GAIN_RED_DB   (gain_red),
        .RSSI          (rssi),
        .RSSI_REF      (rssi_ref),
        .DIG_STEP      (dig_step),
        .AMP1_STEP     (amp1_step),
        .AMP2_STEP     (amp2_step),
        .TARGET_DB     (target_db),
        .CARRIER_SENSE (carrier_sense)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict;
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // Half period of six cycles keeps clear of the two-flop pin sync
    task automatic spi(input logic [7:0] h, input logic [7:0] d,
                       output logic [7:0] r);
        logic [15:0] sh;
        sh = {h, d};
        r = 8'h00;
        csn <= 1'b0;
        cyc(4);
        for (int i = 0; i < 16; i++) begin
            mosi <= sh[15-i];
            cyc(6);
            if (i == 0)
                check({7'h00, miso_oe}, 8'h01);
            if (i >= 8)
                r = {r[6:0], miso};
            sclk <= 1'b1;
            cyc(6);
            sclk <= 1'b0;
        end
        cyc(6);
        csn <= 1'b1;
        cyc(8);
    endtask : spi

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        spi({2'b00, a[5:0]}, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        spi({2'b10, a[5:0]}, 8'h00, d);
    endtask : rd

    // Request pulse of n cycles, then let the step register settle
    task automatic pulse(input int which, input int n);
        case (which)
            0: amp_dn <= 1'b1;
            1: amp_up <= 1'b1;
            2: dig_dn <= 1'b1;
            default: dig_up <= 1'b1;
        endcase
        cyc(n);
        {amp_dn, amp_up, dig_dn, dig_up} <= 4'h0;
        cyc(2);
    endtask : pulse

    task automatic cs(input logic [7:0] a, input logic [7:0] g,
                      input logic [7:0] s, input logic [7:0] f,
                      input logic e);
        chan_ampl <= a;
        gain_red <= g;
        rssi <= s;
        rssi_ref <= f;
        cyc(3);
        check({7'h00, carrier_sense}, {7'h00, e});
    endtask : cs

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] r;
        check(target_db, 8'h21);
        check({5'h00, dig_step}, 8'h07);
        check({7'h00, miso_oe}, 8'h00);
        rd(8'h1b, r);
        check(r, 8'h03);
        rd(8'h1c, r);
        check(r, 8'h40);
    endtask : t_reset

    task automatic t_target;
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            wr(8'h1b, {5'h00, 3'(i)});
            check(target_db, tgt[i]);
        end
        rd(8'h1b, r);
        check(r, 8'h07);
        wr(8'h1b, 8'h03);
    endtask : t_target

    task automatic t_digital;
        wr(8'h1b, 8'h83);
        check({5'h00, dig_step}, 8'h05);
        pulse(3, 3);
        check({5'h00, dig_step}, 8'h05);
        pulse(2, 1);
        check({5'h00, dig_step}, 8'h04);
        wr(8'h1b, 8'hc3);
        check({5'h00, dig_step}, 8'h04);
        wr(8'h1b, 8'h03);
        pulse(3, 4);
        check({5'h00, dig_step}, 8'h07);
    endtask : t_digital

    // Per-stage checks first, then sum checks under lowered caps and once more after the cap is cleared
    task automatic t_amp;
        pulse(0, 1);
        check({5'h00, amp1_step}, 8'h06);
        check({5'h00, amp2_step}, 8'h07);
        pulse(1, 2);
        check({5'h00, amp1_step}, 8'h07);
        wr(8'h1c, 8'h08);
        pulse(0, 2);
        check({5'h00, amp1_step}, 8'h07);
        check({5'h00, amp2_step}, 8'h05);
        wr(8'h1b, 8'h1b);
        cyc(10);
        check({4'h0, 4'(amp1_step) + 4'(amp2_step)}, 8'h08);
        pulse(1, 1);
        check({4'h0, 4'(amp1_step) + 4'(amp2_step)}, 8'h08);
        wr(8'h1b, 8'h3b);
        cyc(16);
        check({4'h0, 4'(amp1_step) + 4'(amp2_step)}, 8'h00);
        wr(8'h1b, 8'h03);
        pulse(1, 1);
        check({4'h0, 4'(amp1_step) + 4'(amp2_step)}, 8'h01);
    endtask : t_amp

    task automatic t_sense;
        wr(8'h1c, 8'h48);
        cs(8'hff, 8'h00, 8'hff, 8'h00, 1'b0);
        wr(8'h1c, 8'h42);
        cs(8'h1e, 8'h04, 8'h00, 8'h00, 1'b0);
        cs(8'h1e, 8'h05, 8'h00, 8'h00, 1'b1);
        wr(8'h1c, 8'h49);
        cs(8'h19, 8'h00, 8'h00, 8'h00, 1'b0);
        cs(8'h1a, 8'h00, 8'h00, 8'h00, 1'b1);
        wr(8'h1b, 8'h07);
        cs(8'h22, 8'h00, 8'h00, 8'h00, 1'b0);
        cs(8'h23, 8'h00, 8'h00, 8'h00, 1'b1);
        wr(8'h1b, 8'h03);
        for (int c = 1; c < 4; c++) begin
            wr(8'h1c, {2'b01, 2'(c), 4'h8});
            cs(8'h00, 8'h00, 8'h1f + rel[c], 8'h20, 1'b0);
            cs(8'h00, 8'h00, 8'h20 + rel[c], 8'h20, 1'b1);
        end
    endtask : t_sense

    task automatic t_regs;
        logic [7:0] r;
        wr(8'h1c, 8'hff);
        rd(8'h1c, r);
        check(r, 8'h7f);
        wr(8'h1d, 8'h55);
        rd(8'h1d, r);
        check(r, 8'h00);
        wr(8'h1c, 8'h40);
    endtask : t_regs

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        cyc(2);
        srst <= 1'b0;
        cyc(4);
        t_reset();
        t_target();
        t_digital();
        t_amp();
        t_sense();
        t_regs();
        give_verdict();
    end

    initial begin
        repeat (60000) @(posedge clock);
        err_count++;
        give_verdict();
    end
endmodule : tb_top
